// ===== tkss_pkg.sv
package tkss_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NKEYS = 24;
  localparam int KW    = 5;
  localparam int LIMW  = 4;
  localparam int BLW   = 8;
  localparam int SLW   = 16;
  localparam int CW    = 24;

  // ---------------------------------------------------------------
  // interface selection
  // ---------------------------------------------------------------
  localparam logic [1:0] STRAP_SHIFT  = 2'h0;
  localparam logic [1:0] STRAP_A      = 2'h1;
  localparam logic [1:0] STRAP_B      = 2'h2;
  localparam logic [6:0] SLV_ADDR_A   = 7'h07;
  localparam logic [6:0] SLV_ADDR_B   = 7'h11;
  localparam logic [6:0] SLV_ADDR_C   = 7'h75;

  // ---------------------------------------------------------------
  // factory settings used in shift-register mode
  // ---------------------------------------------------------------
  localparam logic [BLW-1:0]  FACT_BURST_LEN = 8'h30;
  localparam logic [SLW-1:0]  FACT_SLEEP_MS  = 16'h007D;
  localparam logic [LIMW-1:0] FACT_INNER_LIM = 4'h2;
  localparam logic [LIMW-1:0] FACT_OUTER_LIM = 4'h2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS      = 8;
  localparam int SCL_LOW_NS  = 500;
  localparam int SCL_HIGH_NS = 125000;
  localparam int LATCH_NS    = 500;
  localparam int HOLD_NS     = 75000;
  localparam int MS_NS       = 1000000;
  localparam int SCL_LOW_CYC      = (SCL_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int LATCH_CYC        = (LATCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCL_HIGH_CYC_DEF = (SCL_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC_DEF     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_CYC_DEF       = MS_NS / CLK_NS;

  // ---------------------------------------------------------------
  // carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [LIMW-1:0] inner;
    logic [LIMW-1:0] outer;
  } tkss_limit_t;

  typedef struct packed {
    logic [KW-1:0]  key;
    logic [BLW-1:0] len;
    logic           chirp;
  } tkss_burst_t;

  typedef enum logic [4:0] {
    SC_SLEEP = 5'h01,
    SC_BURST = 5'h02,
    SC_WAIT  = 5'h04,
    SC_NEXT  = 5'h08,
    SC_DONE  = 5'h10
  } tkss_scan_t;

  typedef enum logic [3:0] {
    SH_IDLE  = 4'h1,
    SH_LOW   = 4'h2,
    SH_HIGH  = 4'h4,
    SH_LATCH = 4'h8
  } tkss_shift_t;
endpackage : tkss_pkg

// ===== tkss_top.sv
// How it works
// [R1] inner counter advances on hit, clears on miss
// [R2] each key has own inner counter, limit
// [R3] inner bursts repeat on same key first
// [R4] outer advances on inner limit, resets on miss
// [R5] outer limit reached marks key detected
// [R6] outer advances at most once per scan
// [R7] sleep, timed wake, scan, sleep again
// [R8] host traffic during sleep wakes and scans
// [R9] at least one full scan per wake
// [R10] activity in last scan forces another scan
// [R11] straps pick shift mode or address
// [R12] shift mode drives data and clock pins
// [R13] far register captures on rising edges
// [R14] bits shifted during scan, latch after
// [R15] data bit high means key detected
// [R16] clock idles high, latch pulses low
// [R17] minimum low, high, latch, hold times
// [R18] unshifted keys go out after scan
// [R19] shift mode uses fixed factory settings
// [R20] change alert inactive in shift mode
// [R21] bursts always use chirp modulation
// [R22] alert set on change, cleared by read
// [R23] keys shifted in ascending index order
// [R24] reset clears counters and detect bits
`timescale 1ns/1ps
`default_nettype none
module tkss_top
  import tkss_pkg::*;
#(
  parameter int P_MS_CYC   = MS_CYC_DEF,
  parameter int P_HIGH_CYC = SCL_HIGH_CYC_DEF,
  parameter int P_HOLD_CYC = HOLD_CYC_DEF
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_link_clk,
  input  wire logic                    i_link_xfer_start,
  input  wire logic                    i_link_status1_rd,
  input  wire logic                    i_iface_strap_low,
  input  wire logic                    i_iface_strap_high,
  input  wire tkss_limit_t [NKEYS-1:0] i_key_limits,
  input  wire logic [BLW-1:0]          i_burst_len,
  input  wire logic [SLW-1:0]          i_sleep_ms,
  input  wire logic                    i_burst_done,
  input  wire logic                    i_burst_above,
  output tkss_burst_t                  o_burst,
  output logic                         o_burst_req,
  output logic [NKEYS-1:0]             o_detect,
  output logic                         o_change_alert,
  output logic                         o_awake,
  output logic                         o_slave_en,
  output logic [6:0]                   o_slave_addr,
  output logic                         o_sda,
  output logic                         o_sda_oe_n,
  output logic                         o_scl,
  output logic                         o_scl_oe_n,
  output logic                         o_load_strobe_n
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] f_slave_addr(input logic [1:0] s);
    unique case (s)
      STRAP_A: f_slave_addr = SLV_ADDR_A;
      STRAP_B: f_slave_addr = SLV_ADDR_B;
      default: f_slave_addr = SLV_ADDR_C;
    endcase
  endfunction : f_slave_addr

  function automatic tkss_limit_t f_limit(input logic sr, input tkss_limit_t l);
    f_limit = sr ? tkss_limit_t'{inner: FACT_INNER_LIM, outer: FACT_OUTER_LIM} : l;
  endfunction : f_limit

  localparam int HI_CYC = (P_HIGH_CYC > P_HOLD_CYC) ? P_HIGH_CYC : P_HOLD_CYC;

  // ---------------------------------------------------------------
  // link domain: events become toggles
  // ---------------------------------------------------------------
  logic lk_start_q;
  logic lk_rd_q;

  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lk_start_q <= 1'b0;
      lk_rd_q    <= 1'b0;
    end else begin
      if (i_link_xfer_start) lk_start_q <= ~lk_start_q;
      if (i_link_status1_rd) lk_rd_q <= ~lk_rd_q;
    end
  end

  // ---------------------------------------------------------------
  // synchronisers into the core clock
  // ---------------------------------------------------------------
  logic [2:0] st_sync_q;
  logic [2:0] rd_sync_q;
  logic [2:0] sl_sync_q;
  logic [2:0] sh_sync_q;
  logic [1:0] strap_q;
  logic       host_wake;
  logic       status_rd;
  logic       sr_mode;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_sync_q <= 3'h0;
      rd_sync_q <= 3'h0;
      sl_sync_q <= 3'h0;
      sh_sync_q <= 3'h0;
    end else begin
      st_sync_q <= {st_sync_q[1:0], lk_start_q};
      rd_sync_q <= {rd_sync_q[1:0], lk_rd_q};
      sl_sync_q <= {sl_sync_q[1:0], i_iface_strap_low};
      sh_sync_q <= {sh_sync_q[1:0], i_iface_strap_high};
    end
  end

  assign host_wake = st_sync_q[2] ^ st_sync_q[1];
  assign status_rd = rd_sync_q[2] ^ rd_sync_q[1];

  // strap levels count once second and third stages agree
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_q <= STRAP_SHIFT;
    end else begin
      if (sl_sync_q[1] == sl_sync_q[2]) strap_q[0] <= sl_sync_q[2];
      if (sh_sync_q[1] == sh_sync_q[2]) strap_q[1] <= sh_sync_q[2];
    end
  end

  assign sr_mode = (strap_q == STRAP_SHIFT); // R11

  // ---------------------------------------------------------------
  // scan sequencer state
  // ---------------------------------------------------------------
  tkss_scan_t       st_q;
  logic [KW-1:0]    key_q;
  logic [LIMW-1:0]  inner_q [NKEYS];
  logic [LIMW-1:0]  outer_q [NKEYS];
  logic [NKEYS-1:0] detect_q;
  logic             act_q;
  logic             wake_pend_q;
  logic             shift_idle;
  tkss_limit_t      lim;
  logic             fin;
  logic             hit;
  logic [LIMW:0]    inner_nx;
  logic [LIMW:0]    outer_nx;
  logic             inner_full;
  logic             outer_full;
  logic             det_set;
  logic             det_clr;
  logic             chg;
  logic             scan_start;
  logic             sleep_due;
  logic             activity;

  assign lim        = f_limit(sr_mode, i_key_limits[key_q]); // R2 R19
  assign fin        = (st_q == SC_WAIT) && i_burst_done;
  assign hit        = i_burst_above;
  assign inner_nx   = {1'b0, inner_q[key_q]} + 5'h01;
  assign outer_nx   = {1'b0, outer_q[key_q]} + 5'h01;
  assign inner_full = inner_nx >= {1'b0, lim.inner};
  assign outer_full = outer_nx >= {1'b0, lim.outer};
  assign det_set    = fin && hit && inner_full && outer_full;
  assign det_clr    = fin && !hit;
  assign chg        = (det_set && !detect_q[key_q]) || (det_clr && detect_q[key_q]);
  assign activity   = act_q || (|detect_q) || wake_pend_q;
  assign scan_start = ((st_q == SC_SLEEP) && (sleep_due || wake_pend_q))
                   || ((st_q == SC_DONE) && shift_idle && activity);

  // main scan sequence
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q  <= SC_SLEEP;
      key_q <= '0;
    end else begin
      unique case (st_q)
        SC_SLEEP: if (scan_start) begin // R7 R8
          st_q  <= SC_BURST;
          key_q <= '0;
        end
        SC_BURST: st_q <= SC_WAIT;
        SC_WAIT: if (fin) begin
          if (hit && !inner_full) st_q <= SC_BURST; // R3
          else st_q <= SC_NEXT;
        end
        SC_NEXT: if (key_q == KW'(NKEYS - 1)) begin
          st_q <= SC_DONE;
        end else begin
          key_q <= key_q + 5'h01;
          st_q  <= SC_BURST;
        end
        SC_DONE: if (shift_idle) begin // R9
          st_q  <= activity ? SC_BURST : SC_SLEEP; // R10
          key_q <= '0;
        end
      endcase
    end
  end

  // per-key inner and outer counters
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < NKEYS; k++) begin // R24
        inner_q[k] <= '0;
        outer_q[k] <= '0;
      end
    end else if (fin) begin
      if (!hit) begin
        inner_q[key_q] <= '0; // R1
        outer_q[key_q] <= '0; // R4
      end else if (inner_full) begin
        inner_q[key_q] <= '0;
        if (!outer_full) outer_q[key_q] <= outer_nx[LIMW-1:0]; // R4 R6
      end else begin
        inner_q[key_q] <= inner_nx[LIMW-1:0]; // R1
      end
    end
  end

  // detect status and scan activity
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      detect_q <= '0; // R24
      act_q    <= 1'b0;
    end else begin
      if (det_set) detect_q[key_q] <= 1'b1; // R5
      else if (det_clr) detect_q[key_q] <= 1'b0;
      if (chg) act_q <= 1'b1;
      else if (scan_start) act_q <= 1'b0;
    end
  end

  // host wake request, set wins over clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_pend_q <= 1'b0;
    end else if (host_wake) begin
      wake_pend_q <= 1'b1; // R8
    end else if (scan_start) begin
      wake_pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sleep timer
  // ---------------------------------------------------------------
  logic [CW-1:0]  tick_q;
  logic [SLW-1:0] slept_q;
  logic [SLW-1:0] sleep_lim;
  logic           ms_tick;

  assign sleep_lim = sr_mode ? FACT_SLEEP_MS : i_sleep_ms; // R19
  assign ms_tick   = (tick_q == CW'(P_MS_CYC - 1));
  assign sleep_due = ms_tick && ((slept_q + 16'h0001) >= sleep_lim); // R7

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_q  <= '0;
      slept_q <= '0;
    end else if (st_q != SC_SLEEP) begin
      tick_q  <= '0;
      slept_q <= '0;
    end else if (ms_tick) begin
      tick_q  <= '0;
      slept_q <= slept_q + 16'h0001;
    end else begin
      tick_q <= tick_q + 24'h000001;
    end
  end

  // ---------------------------------------------------------------
  // shift-register output engine
  // ---------------------------------------------------------------
  tkss_shift_t   sh_q;
  logic [KW-1:0] ptr_q;
  logic [CW-1:0] cnt_q;
  logic          sda_q;
  logic          scl_q;
  logic          latch_n_q;
  logic          latched_q;
  logic [KW-1:0] avail;

  // keys below avail are finished in this scan
  assign avail      = (st_q == SC_DONE) ? KW'(NKEYS) : key_q; // R14 R18
  assign shift_idle = !sr_mode || latched_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sh_q      <= SH_IDLE;
      ptr_q     <= KW'(NKEYS);
      cnt_q     <= '0;
      sda_q     <= 1'b0;
      scl_q     <= 1'b1;
      latch_n_q <= 1'b1;
      latched_q <= 1'b1;
    end else begin
      unique case (sh_q)
        SH_IDLE: if (scan_start) begin
          ptr_q     <= '0;
          latched_q <= !sr_mode;
        end else if (sr_mode && !latched_q) begin
          cnt_q <= '0;
          if (ptr_q < avail) begin
            sda_q <= detect_q[ptr_q]; // R15 R23
            scl_q <= 1'b0; // R16
            sh_q  <= SH_LOW;
          end else if (ptr_q == KW'(NKEYS)) begin
            latch_n_q <= 1'b0; // R14 R16
            sh_q      <= SH_LATCH;
          end
        end
        SH_LOW: if (cnt_q == CW'(SCL_LOW_CYC - 1)) begin // R17
          cnt_q <= '0;
          scl_q <= 1'b1;
          sh_q  <= SH_HIGH;
        end else begin
          cnt_q <= cnt_q + 24'h000001;
        end
        SH_HIGH: if (cnt_q == CW'(HI_CYC - 1)) begin // R17
          ptr_q <= ptr_q + 5'h01;
          sh_q  <= SH_IDLE;
        end else begin
          cnt_q <= cnt_q + 24'h000001;
        end
        SH_LATCH: if (cnt_q == CW'(LATCH_CYC - 1)) begin // R17
          latch_n_q <= 1'b1;
          latched_q <= 1'b1;
          sh_q      <= SH_IDLE;
        end else begin
          cnt_q <= cnt_q + 24'h000001;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // change alert and interface outputs
  // ---------------------------------------------------------------
  logic       alert_q;
  logic [6:0] addr_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      alert_q <= 1'b0;
      addr_q  <= SLV_ADDR_C;
    end else begin
      addr_q <= f_slave_addr(strap_q); // R11
      if (sr_mode) alert_q <= 1'b0; // R20
      else if (chg) alert_q <= 1'b1; // R22
      else if (status_rd) alert_q <= 1'b0;
    end
  end

  assign o_burst         = '{key: key_q, len: sr_mode ? FACT_BURST_LEN : i_burst_len,
                             chirp: 1'b1}; // R21
  assign o_burst_req     = (st_q == SC_BURST);
  assign o_detect        = detect_q;
  assign o_change_alert  = alert_q;
  assign o_awake         = (st_q != SC_SLEEP);
  assign o_slave_en      = !sr_mode; // R12
  assign o_slave_addr    = addr_q;
  assign o_sda           = sda_q;
  assign o_scl           = scl_q;
  assign o_sda_oe_n      = !sr_mode; // R12
  assign o_scl_oe_n      = !sr_mode;
  assign o_load_strobe_n = latch_n_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  logic [CW-1:0] low_len_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) low_len_q <= '0;
    else if (scl_q) low_len_q <= '0;
    else low_len_q <= low_len_q + 24'h000001;
  end

  sequence s_hit_short;
    fin && hit && !inner_full;
  endsequence
  sequence s_miss;
    fin && !hit;
  endsequence

  chk_inner_clear: assert property (s_miss |=> inner_q[$past(key_q)] == '0 // R1
    && outer_q[$past(key_q)] == '0) else $error("miss did not clear counters");
  chk_burst_same_key: assert property (s_hit_short |=> st_q == SC_BURST // R3
    && key_q == $past(key_q) ##1 st_q == SC_WAIT) else $error("burst moved off key");
  chk_detect_declare: assert property (det_set |=> detect_q[$past(key_q)]) // R5
    else $error("detect not declared");
  chk_rescan_active: assert property ((st_q == SC_DONE) && shift_idle && activity // R10
    |=> st_q == SC_BURST && key_q == '0) else $error("active scan went to sleep");
  chk_wake_scan: assert property ((st_q == SC_SLEEP) && wake_pend_q // R8
    |=> st_q == SC_BURST ##1 st_q == SC_WAIT) else $error("wake did not start scan");
  chk_alert_quiet: assert property (sr_mode |=> !o_change_alert) // R20
    else $error("alert active in shift mode");
  chk_alert_set: assert property (!sr_mode && chg |=> o_change_alert) // R22
    else $error("alert missed change");
  chk_pins_driven: assert property (sr_mode |-> !o_sda_oe_n && !o_scl_oe_n // R12
    && !o_slave_en) else $error("shift pins not driven");
  chk_scl_low_time: assert property ($rose(o_scl) |-> // R17
    $past(low_len_q) >= CW'(SCL_LOW_CYC - 1)) else $error("clock low too short");
  chk_latch_after_scan: assert property ($fell(o_load_strobe_n) |-> // R14
    ptr_q == KW'(NKEYS) && st_q == SC_DONE ##1 !o_load_strobe_n[*8])
    else $error("latch out of place");
  chk_chirp_on: assert property (o_burst_req |-> o_burst.chirp) // R21
    else $error("burst without chirp");

endmodule : tkss_top
`default_nettype wire

// ===== tkss_shreg_model.sv
`timescale 1ns/1ps
`default_nettype none
module tkss_shreg_model #(
  parameter int N       = 24,
  parameter int HOLD_NS = 40
) (
  input  wire logic         i_reset_n,
  input  wire logic         i_sda,
  input  wire logic         i_scl,
  input  wire logic         i_load_n,
  output var  logic [N-1:0] o_q,
  output var  int           o_bits,
  output var  int           o_min_low,
  output var  int           o_min_high,
  output var  int           o_min_latch,
  output var  logic         o_hold_bad
);
  // ---------------------------------------------------------------
  // external shift register chain with timing probes
  // ---------------------------------------------------------------
  logic [N-1:0] sr_q;
  int           bits;
  realtime      t_fall;
  realtime      t_rise;
  realtime      t_load;

  // start with empty stages and huge minimum widths
  initial begin
    sr_q = '0;
    o_q = '0;
    bits = 0;
    o_bits = 0;
    o_hold_bad = 1'b0;
    o_min_low = 1000000;
    o_min_high = 1000000;
    o_min_latch = 1000000;
    t_fall = 0.0;
    t_rise = -1.0e9;
    t_load = 0.0;
  end

  // rising shift clock captures the data line
  always @(posedge i_scl) if (i_reset_n === 1'b1) begin
    sr_q = {sr_q[N-2:0], i_sda};
    bits = bits + 1;
    if (int'($realtime - t_fall) < o_min_low) o_min_low = int'($realtime - t_fall);
    t_rise = $realtime;
  end

  // falling shift clock ends a high phase
  always @(negedge i_scl) if (i_reset_n === 1'b1) begin
    if (int'($realtime - t_rise) < o_min_high) o_min_high = int'($realtime - t_rise);
    t_fall = $realtime;
  end

  // data may only move once the hold time after the rise is over
  always @(i_sda) if (i_reset_n === 1'b1 && ($realtime - t_rise) < HOLD_NS) o_hold_bad = 1'b1;

  // rising load strobe copies the stages to the outputs
  always @(negedge i_load_n) t_load = $realtime;
  always @(posedge i_load_n) if (i_reset_n === 1'b1) begin
    o_q = sr_q;
    o_bits = bits;
    bits = 0;
    if (int'($realtime - t_load) < o_min_latch) o_min_latch = int'($realtime - t_load);
  end
  always @(negedge i_reset_n) bits = 0;
endmodule : tkss_shreg_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tkss_pkg::*;
  localparam int MS = 20;
  localparam int HI = 10, HO = 5;
  logic                    i_clk, i_reset_n, i_link_clk, i_link_xfer_start, i_link_status1_rd;
  logic                    i_iface_strap_low, i_iface_strap_high, i_burst_done, i_burst_above;
  tkss_limit_t [NKEYS-1:0] i_key_limits;
  logic [BLW-1:0]          i_burst_len;
  logic [SLW-1:0]          i_sleep_ms;
  tkss_burst_t             o_burst;
  logic                    o_burst_req, o_change_alert, o_awake, o_slave_en, o_sda, o_sda_oe_n;
  logic                    o_scl, o_scl_oe_n, o_load_strobe_n, exp_alert, two_wire, noise;
  logic                    lk_run, hold_bad;
  logic [NKEYS-1:0]        o_detect, pressed, exp_det, sh_q, exp_rev;
  logic [6:0]              o_slave_addr;
  logic [6:0]              addr_tab [4];
  int num_errors, compares, seed, cycles, scan_cnt, exp_key, rgen, sh_bits;
  int min_low, min_high, min_latch, n, sc;
  int exp_in [NKEYS], exp_out [NKEYS];

  tkss_top #(.P_MS_CYC(MS), .P_HIGH_CYC(HI), .P_HOLD_CYC(HO)) uut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_link_clk(i_link_clk),
    .i_link_xfer_start(i_link_xfer_start), .i_link_status1_rd(i_link_status1_rd),
    .i_iface_strap_low(i_iface_strap_low), .i_iface_strap_high(i_iface_strap_high),
    .i_key_limits(i_key_limits), .i_burst_len(i_burst_len), .i_sleep_ms(i_sleep_ms),
    .i_burst_done(i_burst_done), .i_burst_above(i_burst_above), .o_burst(o_burst),
    .o_burst_req(o_burst_req), .o_detect(o_detect), .o_change_alert(o_change_alert),
    .o_awake(o_awake), .o_slave_en(o_slave_en), .o_slave_addr(o_slave_addr), .o_sda(o_sda),
    .o_sda_oe_n(o_sda_oe_n), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n),
    .o_load_strobe_n(o_load_strobe_n));

  tkss_shreg_model #(.N(NKEYS), .HOLD_NS(HO * CLK_NS)) shreg (
    .i_reset_n(i_reset_n), .i_sda(o_sda), .i_scl(o_scl), .i_load_n(o_load_strobe_n),
    .o_q(sh_q), .o_bits(sh_bits), .o_min_low(min_low), .o_min_high(min_high),
    .o_min_latch(min_latch), .o_hold_bad(hold_bad));

  // ---------------------------------------------------------------
  // clocks, timeout and shared tasks
  // ---------------------------------------------------------------
  // core clock runs free, link clock only while host traffic is sent
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #7;
    forever #15 if (lk_run) i_link_clk = ~i_link_clk;
  end
  // hang guard
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  task automatic check(input logic ok, input string msg);
    compares = compares + 1;
    if (ok !== 1'b1) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check

  task automatic finish_test();
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // two-tier confirmation model for the key in work
  task automatic model_done(input logic above);
    int   li;
    int   lo;
    logic old;
    li = two_wire ? int'(i_key_limits[exp_key].inner) : int'(FACT_INNER_LIM);
    lo = two_wire ? int'(i_key_limits[exp_key].outer) : int'(FACT_OUTER_LIM);
    old = exp_det[exp_key];
    if (above) exp_in[exp_key]++;
    else begin
      exp_in[exp_key] = 0;
      exp_out[exp_key] = 0;
      exp_det[exp_key] = 1'b0;
    end
    if (above && exp_in[exp_key] >= ((li == 0) ? 1 : li)) begin
      exp_in[exp_key] = 0;
      exp_out[exp_key]++;
      if (exp_out[exp_key] >= lo) exp_det[exp_key] = 1'b1;
    end
    if (two_wire && old !== exp_det[exp_key]) exp_alert = 1'b1;
    if (exp_in[exp_key] == 0) begin
      if (exp_key == NKEYS - 1) scan_cnt++;
      exp_key = (exp_key + 1) % NKEYS;
    end
  endtask : model_done

  task automatic do_reset(input logic [1:0] strap);
    @(posedge i_clk);
    #1;
    i_reset_n = 1'b0;
    {i_iface_strap_high, i_iface_strap_low} = strap;
    two_wire = (strap != 2'h0);
    rgen++;
    exp_key = 0;
    exp_det = '0;
    exp_alert = 1'b0;
    scan_cnt = 0;
    foreach (exp_in[k]) exp_in[k] = 0;
    foreach (exp_out[k]) exp_out[k] = 0;
    repeat (2) @(posedge i_clk);
    #1;
    check(o_detect === '0 && o_burst_req === 1'b0 && o_awake === 1'b0, "reset state");
    check(o_scl === 1'b1 && o_load_strobe_n === 1'b1, "reset pins");
    i_reset_n = 1'b1;
    repeat (6) @(posedge i_clk);
    #1;
  endtask : do_reset

  task automatic wait_scans(input int num, input int lim);
    int c;
    c = 0;
    while (scan_cnt < num && c < lim) begin
      @(posedge i_clk);
      #1 c++;
    end
    check(scan_cnt >= num, "scan progress");
  endtask : wait_scans

  task automatic wait_awake(input logic val, input int lim);
    int c;
    c = 0;
    while (o_awake !== val && c < lim) begin
      @(posedge i_clk);
      #1 c++;
    end
    check(o_awake === val, "awake state");
  endtask : wait_awake

  task automatic link_pulse(input logic rd);
    lk_run = 1'b1;
    @(posedge i_link_clk);
    #1;
    if (rd) i_link_status1_rd = 1'b1;
    else i_link_xfer_start = 1'b1;
    @(posedge i_link_clk);
    #1;
    i_link_status1_rd = 1'b0;
    i_link_xfer_start = 1'b0;
    repeat (2) @(posedge i_link_clk);
    @(negedge i_link_clk);
    lk_run = 1'b0;
  endtask : link_pulse

  // ---------------------------------------------------------------
  // acquisition front end and output watchers
  // ---------------------------------------------------------------
  // answers each burst request after a random delay, updates the model
  initial begin : front_end
    int dly;
    int g;
    forever begin
      @(negedge i_clk);
      if (o_burst_req === 1'b1 && i_reset_n === 1'b1) begin
        g = rgen;
        check(o_burst.key === exp_key[KW-1:0], "burst key");
        check(o_burst.chirp === 1'b1, "burst chirp");
        check(o_burst.len === (two_wire ? i_burst_len : 8'h30), "burst length");
        check(o_detect === exp_det, "detect status");
        check(o_change_alert === exp_alert, "change alert");
        dly = $unsigned($random(seed)) % 3;
        repeat (dly + 1) @(posedge i_clk);
        #1;
        i_burst_done = 1'b1;
        i_burst_above = pressed[exp_key] ^ (noise && ($unsigned($random(seed)) % 8 == 0));
        @(posedge i_clk);
        #1;
        i_burst_done = 1'b0;
        if (g == rgen && i_reset_n === 1'b1) model_done(i_burst_above);
      end
    end
  end

  // each load strobe presents the whole frame, key 0 in the last stage
  always @(posedge o_load_strobe_n) if (i_reset_n === 1'b1 && !two_wire) begin
    #1;
    exp_rev = {<<{exp_det}};
    check(sh_q === exp_rev, "latched outputs");
    check(sh_bits == NKEYS && o_scl === 1'b1, "bits per frame");
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h47ba;
    {num_errors, compares, cycles, scan_cnt, exp_key, rgen} = '0;
    {i_reset_n, i_link_xfer_start, i_link_status1_rd, i_burst_done, i_burst_above} = '0;
    {i_iface_strap_low, i_iface_strap_high, lk_run, noise, two_wire, exp_alert} = '0;
    addr_tab = '{7'h00, 7'h07, 7'h11, 7'h75};
    pressed = '0;
    exp_det = '0;
    i_burst_len = 8'h5A;
    i_sleep_ms = 16'h0001;
    foreach (i_key_limits[k]) begin
      i_key_limits[k].inner = LIMW'($unsigned($random(seed)) % 4);
      i_key_limits[k].outer = LIMW'($unsigned($random(seed)) % 3);
    end
    repeat (2) @(posedge i_clk);
    // every strap setting, shift mode last
    for (int s = 1; s < 5; s++) begin
      do_reset(2'(s % 4));
      check(o_slave_en === 1'(s != 4), "slave enable");
      check(s == 4 || o_slave_addr === addr_tab[s], "slave address");
      check({o_sda_oe_n, o_scl_oe_n} === {2{1'(s != 4)}}, "pin drive");
      check(o_change_alert === 1'b0, "alert idle");
    end
    // shift mode with noisy keys and ignored settings
    noise = 1'b1;
    pressed = NKEYS'($random(seed));
    wait_scans(3, 30000);
    check(min_low >= 500 && min_latch >= 500, "low widths");
    check(min_high >= HI * CLK_NS && hold_bad === 1'b0, "high width and hold");
    // two-wire mode with per-key limits
    noise = 1'b0;
    pressed = NKEYS'($random(seed)) | 24'h000001;
    do_reset(2'h1);
    wait_awake(1'b1, 40);
    wait_scans(3, 5000);
    n = 0;
    repeat (300) begin
      @(negedge i_clk);
      n = n + int'(o_awake !== 1'b1);
    end
    check(n == 0, "awake while touched");
    i_sleep_ms = 16'hFFFF;
    pressed = '0;
    wait_awake(1'b0, 3000);
    check(o_change_alert === 1'b1, "alert after release");
    link_pulse(1'b1);
    repeat (8) @(posedge i_clk);
    exp_alert = 1'b0;
    check(o_change_alert === 1'b0, "alert cleared by read");
    repeat (50) @(posedge i_clk);
    check(o_awake === 1'b0, "still asleep");
    sc = scan_cnt;
    link_pulse(1'b0);
    wait_awake(1'b1, 20);
    wait_awake(1'b0, 3000);
    check(scan_cnt > sc, "full scan after wake");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
